// >>> hw/link_ctl_pkg.sv
// Constants for the per-port link control register block.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
package link_ctl_pkg;

  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;

  // Register byte addresses.
  localparam logic [7:0] LINK_CONTROL_ADDR = 8'h50;
  localparam logic [7:0] PORT_STATUS_ADDR  = 8'h58;

  // Field positions inside link_control.
  localparam int ASPM_LSB      = 0;
  localparam int ASPM_MSB      = 1;
  localparam int BOUNDARY_BIT  = 3;
  localparam int LINK_OFF_BIT  = 4;
  localparam int RETRAIN_BIT   = 5;
  localparam int REFCLK_BIT    = 6;
  localparam int SYNC_BIT      = 7;
  localparam int CLKPM_BIT     = 8;
  localparam int WIDTH_BLK_BIT = 9;
  localparam int BW_IRQ_BIT    = 10;
  localparam int ABW_IRQ_BIT   = 11;

  // Field positions inside the port status register.
  localparam int ST_BW_FLAG_BIT  = 0;
  localparam int ST_ABW_FLAG_BIT = 1;
  localparam int ST_LINK_OFF_BIT = 2;
  localparam int ST_RETRAIN_BIT  = 3;
  localparam int ST_RECOV_BIT    = 4;

  localparam logic [1:0] ASPM_RESET = 2'h0;

  // Count of consecutive autonomous-change ordered sets.
  localparam int AUTO_TS_COUNT = 8;

  typedef enum logic [1:0] {
    RT_IDLE    = 2'b00,
    RT_REQUEST = 2'b01,
    RT_WAIT    = 2'b11,
    RT_DONE    = 2'b10
  } retrain_state_type;

endpackage : link_ctl_pkg

// >>> hw/sticky_flag.sv
// One sticky status flag: hardware set wins over a software clear.
// Assumes set and clear come from the same clock domain.
`timescale 1ns/100ps
module sticky_flag
(
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic enable_in,
  input  wire logic set_in,
  input  wire logic clear_in,
  output logic      flag_out
);

  logic flag_reg;
  logic flag_next;

  assign flag_next = !enable_in ? 1'b0 :
                     set_in     ? 1'b1 :
                     clear_in   ? 1'b0 : flag_reg;
  assign flag_out  = flag_reg;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next;
  end

endmodule : sticky_flag

// >>> hw/ts_run_counter.sv
// Counts consecutive training ordered sets that carry the autonomous
// change indication and pulses once when the run reaches the target.
// Assumes ordered-set strobes arrive on the same clock as this counter.
`timescale 1ns/100ps
module ts_run_counter
#(
  parameter int TARGET = 8
)
(
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic os_valid_in,
  input  wire logic os_auto_in,
  output logic      hit_out
);

  localparam int CW = $clog2(TARGET + 1);

  if (TARGET < 1)
  begin : bad_target
    $error("ts_run_counter: TARGET must be at least one.");
  end

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          hit_next;
  logic          at_target;

  assign at_target  = (count_reg == CW'(TARGET - 1));
  assign hit_next   = os_valid_in && os_auto_in && at_target;
  assign count_next = !os_valid_in ? count_reg :
                      !os_auto_in  ? '0 :
                      at_target    ? '0 : count_reg + 1'b1;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count_reg <= '0;
      hit_out   <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      hit_out   <= hit_next;
    end
  end

endmodule : ts_run_counter

// >>> hw/link_control_reg.sv
// Per-port link control register with retrain sequencing, bandwidth
// status flags and bandwidth interrupt request.
// Assumes a classic Wishbone master, a physical layer on the same clock
// that acknowledges a recovery request, and static strap inputs.
//
// Behaviour
// - Bits 1:0 select power state entry: none, L0s, L1 or both.
// - Power field resets disabled; a serial memory load may replace it.
// - Bit 3 completion boundary reads zero and ignores writes.
// - Downstream port: link_off bit holds the link disabled while set.
// - Upstream port: link_off reads zero and ignored unless unlocked.
// - Writing one to retrain bit sends training machine to Recovery.
// - Retrain bit always reads zero.
// - Fields written with retrain take effect in that retraining.
// - Upstream port: retrain reads zero and is ignored unless unlocked.
// - Bit 6 read-write flag marks a shared reference clock.
// - Bit 7 forces extra ordered sets on L0s exit and Recovery.
// - Bit 8 clock power management reads zero.
// - Bit 9 blocks autonomous width change except reliability reduction.
// - In 1.1 mode the width block bit reads zero.
// - Bit 10 enables bandwidth-management interrupt; zero if unsupported.
// - Bit 11 enables autonomous-bandwidth interrupt; zero if unsupported.
// - Bandwidth flag sets when a requested retrain ends without link down.
// - Downstream: autonomous flag sets after eight consecutive marked sets.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
module link_control_reg
#(
  parameter int AUTO_TS_RUN = link_ctl_pkg::AUTO_TS_COUNT
)
(
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // Wishbone slave.
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // Static configuration.
  input  wire logic        downstream_in,
  input  wire logic        upstream_ctrl_unlock_in,
  input  wire logic        bw_notify_capable_in,
  input  wire logic        legacy_mode_in,
  // Serial configuration memory load of the power field.
  input  wire logic        eeprom_load_in,
  input  wire logic [1:0]  eeprom_aspm_in,
  // Physical layer.
  input  wire logic        recovery_ack_in,
  input  wire logic        retrain_done_in,
  input  wire logic        dl_down_in,
  input  wire logic        reliability_bw_change_in,
  input  wire logic        os_valid_in,
  input  wire logic        os_auto_change_in,
  output logic [1:0]       aspm_enable_out,
  output logic             link_off_out,
  output logic             recovery_req_out,
  output logic             shared_refclk_flag_out,
  output logic             extended_sync_force_out,
  output logic             autonomous_width_block_out,
  output logic             bw_irq_out
);

  if (AUTO_TS_RUN < 1)
  begin : bad_run_length
    $error("link_control_reg: AUTO_TS_RUN must be at least one.");
  end

  // Every field position must fit the view widths used below.
  if (link_ctl_pkg::ABW_IRQ_BIT > 15)
  begin : bad_control_map
    $error("link_control_reg: control fields must fit in 16 bits.");
  end

  if (link_ctl_pkg::ST_RECOV_BIT > 4)
  begin : bad_status_map
    $error("link_control_reg: status fields must fit in 5 bits.");
  end

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic ack_reg;
  wire  bus_req     = wb_cyc_in && wb_stb_in && !ack_reg;
  wire  sel_ctl     = (wb_adr_in == link_ctl_pkg::LINK_CONTROL_ADDR);
  wire  sel_sts     = (wb_adr_in == link_ctl_pkg::PORT_STATUS_ADDR);
  wire  wr_ctl      = bus_req && wb_we_in && sel_ctl;
  wire  wr_sts      = bus_req && wb_we_in && sel_sts;
  wire  wr_lo       = wr_ctl && wb_sel_in[0];
  wire  wr_hi       = wr_ctl && wb_sel_in[1];
  wire  wr_sts_lo   = wr_sts && wb_sel_in[0];

  // Feature qualifiers.
  wire  port_ctl_ok = downstream_in || upstream_ctrl_unlock_in;
  wire  bw_ok       = bw_notify_capable_in && !legacy_mode_in;
  wire  width_ok    = !legacy_mode_in;

  // ==========================================================
  // Control fields
  // ==========================================================
  logic [1:0] aspm_reg;
  logic [1:0] aspm_next;
  logic       link_off_reg;
  logic       link_off_next;
  logic       refclk_reg;
  logic       refclk_next;
  logic       sync_reg;
  logic       sync_next;
  logic       width_blk_reg;
  logic       width_blk_next;
  logic       bw_ien_reg;
  logic       bw_ien_next;
  logic       abw_ien_reg;
  logic       abw_ien_next;

  // A serial memory load wins over a bus write in the same cycle.
  assign aspm_next =
    eeprom_load_in ? eeprom_aspm_in :
    wr_lo ? wb_dat_in[link_ctl_pkg::ASPM_MSB:link_ctl_pkg::ASPM_LSB]
          : aspm_reg;
  assign link_off_next = !port_ctl_ok ? 1'b0 :
    wr_lo ? wb_dat_in[link_ctl_pkg::LINK_OFF_BIT] : link_off_reg;
  assign refclk_next = wr_lo ? wb_dat_in[link_ctl_pkg::REFCLK_BIT]
                             : refclk_reg;
  assign sync_next = wr_lo ? wb_dat_in[link_ctl_pkg::SYNC_BIT]
                           : sync_reg;
  assign width_blk_next = !width_ok ? 1'b0 :
    wr_hi ? wb_dat_in[link_ctl_pkg::WIDTH_BLK_BIT] : width_blk_reg;
  assign bw_ien_next = !bw_ok ? 1'b0 :
    wr_hi ? wb_dat_in[link_ctl_pkg::BW_IRQ_BIT] : bw_ien_reg;
  assign abw_ien_next = !bw_ok ? 1'b0 :
    wr_hi ? wb_dat_in[link_ctl_pkg::ABW_IRQ_BIT] : abw_ien_reg;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      aspm_reg     <= link_ctl_pkg::ASPM_RESET;
      link_off_reg <= 1'b0;
    end
    else
    begin
      aspm_reg     <= aspm_next;
      link_off_reg <= link_off_next;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      refclk_reg <= 1'b0;
      sync_reg   <= 1'b0;
    end
    else
    begin
      refclk_reg <= refclk_next;
      sync_reg   <= sync_next;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      width_blk_reg <= 1'b0;
      bw_ien_reg    <= 1'b0;
      abw_ien_reg   <= 1'b0;
    end
    else
    begin
      width_blk_reg <= width_blk_next;
      bw_ien_reg    <= bw_ien_next;
      abw_ien_reg   <= abw_ien_next;
    end
  end

  // ==========================================================
  // Retrain sequencer
  // ==========================================================
  // The trigger is not stored as a field. Because the request reaches the
  // physical layer one cycle after the write, every field written together
  // with it is already in place when recovery starts.
  wire retrain_wr = wr_lo && wb_dat_in[link_ctl_pkg::RETRAIN_BIT]
                    && port_ctl_ok;

  link_ctl_pkg::retrain_state_type rt_reg;
  link_ctl_pkg::retrain_state_type rt_next;
  logic                            rt_down_reg;
  logic                            rt_down_next;

  always_comb
  begin
    rt_next      = rt_reg;
    rt_down_next = rt_down_reg || dl_down_in;
    case (rt_reg)
      link_ctl_pkg::RT_IDLE:
      begin
        rt_down_next = 1'b0;
        if (retrain_wr)
          rt_next = link_ctl_pkg::RT_REQUEST;
      end
      link_ctl_pkg::RT_REQUEST:
        if (recovery_ack_in)
          rt_next = link_ctl_pkg::RT_WAIT;
      link_ctl_pkg::RT_WAIT:
        if (retrain_done_in)
          rt_next = link_ctl_pkg::RT_DONE;
      link_ctl_pkg::RT_DONE:
        rt_next = link_ctl_pkg::RT_IDLE;
      default:
        rt_next = link_ctl_pkg::RT_IDLE;
    endcase
    // Checking the next value lets a write that sets link_off and the
    // retrain bit together leave the link down with no request raised.
    if (link_off_next)
      rt_next = link_ctl_pkg::RT_IDLE;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rt_reg      <= link_ctl_pkg::RT_IDLE;
      rt_down_reg <= 1'b0;
    end
    else
    begin
      rt_reg      <= rt_next;
      rt_down_reg <= rt_down_next;
    end
  end

  // Retrain completed without passing through link down.
  wire retrain_ok = (rt_reg == link_ctl_pkg::RT_DONE) && !rt_down_reg;

  // ==========================================================
  // Bandwidth status flags
  // ==========================================================
  logic bw_flag;
  logic abw_flag;
  logic auto_hit;

  // Only a downstream port counts ordered sets toward the autonomous flag.
  ts_run_counter #(
    .TARGET      (AUTO_TS_RUN)
  ) u_ts_run (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .os_valid_in (os_valid_in && downstream_in),
    .os_auto_in  (os_auto_change_in),
    .hit_out     (auto_hit)
  );

  // A link down in the same cycle vetoes a reliability-driven change.
  sticky_flag u_bw_flag (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .enable_in (bw_ok),
    .set_in    (retrain_ok || (reliability_bw_change_in && !dl_down_in)),
    .clear_in  (wr_sts_lo && wb_dat_in[link_ctl_pkg::ST_BW_FLAG_BIT]),
    .flag_out  (bw_flag)
  );

  sticky_flag u_abw_flag (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .enable_in (bw_ok),
    .set_in    (auto_hit),
    .clear_in  (wr_sts_lo && wb_dat_in[link_ctl_pkg::ST_ABW_FLAG_BIT]),
    .flag_out  (abw_flag)
  );

  logic irq_reg;
  logic irq_next;

  // The request stands as a level while a flag and its enable are both set.
  assign irq_next = (bw_flag && bw_ien_reg) || (abw_flag && abw_ien_reg);

  // ==========================================================
  // Read data and outputs
  // ==========================================================
  logic [15:0] ctl_view;
  always_comb
  begin
    ctl_view = '0;
    ctl_view[link_ctl_pkg::ASPM_MSB:link_ctl_pkg::ASPM_LSB] = aspm_reg;
    ctl_view[link_ctl_pkg::BOUNDARY_BIT]  = 1'b0;
    ctl_view[link_ctl_pkg::LINK_OFF_BIT]  = link_off_reg && port_ctl_ok;
    ctl_view[link_ctl_pkg::RETRAIN_BIT]   = 1'b0;
    ctl_view[link_ctl_pkg::REFCLK_BIT]    = refclk_reg;
    ctl_view[link_ctl_pkg::SYNC_BIT]      = sync_reg;
    ctl_view[link_ctl_pkg::CLKPM_BIT]     = 1'b0;
    ctl_view[link_ctl_pkg::WIDTH_BLK_BIT] = width_blk_reg;
    ctl_view[link_ctl_pkg::BW_IRQ_BIT]    = bw_ien_reg;
    ctl_view[link_ctl_pkg::ABW_IRQ_BIT]   = abw_ien_reg;
  end

  logic [4:0] sts_view;
  always_comb
  begin
    sts_view = '0;
    sts_view[link_ctl_pkg::ST_BW_FLAG_BIT]  = bw_flag;
    sts_view[link_ctl_pkg::ST_ABW_FLAG_BIT] = abw_flag;
    sts_view[link_ctl_pkg::ST_LINK_OFF_BIT] = link_off_reg;
    sts_view[link_ctl_pkg::ST_RETRAIN_BIT]  = (rt_reg != link_ctl_pkg::RT_IDLE);
    sts_view[link_ctl_pkg::ST_RECOV_BIT]    = recovery_req_out;
  end

  wire [31:0] rd_next = sel_ctl ? {16'h0000, ctl_view} :
                        sel_sts ? {27'h0, sts_view} : 32'h00000000;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ack_reg    <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end
    else
    begin
      ack_reg    <= bus_req;
      wb_dat_out <= bus_req ? rd_next : wb_dat_out;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_next;
  end

  assign wb_ack_out                 = ack_reg;
  assign aspm_enable_out            = aspm_reg;
  assign link_off_out               = link_off_reg;
  assign recovery_req_out           = (rt_reg == link_ctl_pkg::RT_REQUEST);
  assign shared_refclk_flag_out     = refclk_reg;
  assign extended_sync_force_out    = sync_reg;
  assign autonomous_width_block_out = width_blk_reg;
  assign bw_irq_out                 = irq_reg;

endmodule : link_control_reg

// >>> sim/phy_model.sv
// Physical layer partner: answers a recovery request after a short or
// long latency, then reports the end of retraining three cycles later.
// Assumes the same clock and reset as the register block.
`timescale 1ns/100ps
module phy_model
(
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic recovery_req_in,
  input  wire logic slow_in,
  output logic      recovery_ack_out,
  output logic      retrain_done_out
);
  logic [3:0]      cnt_reg;
  wire logic [3:0] lat = slow_in ? 4'h9 : 4'h2;
  wire logic [3:0] fin = lat + 4'h3;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_reg <= 4'h0;
    else if (cnt_reg != 4'h0)
      cnt_reg <= (cnt_reg == fin) ? 4'h0 : cnt_reg + 4'h1;
    else if (recovery_req_in)
      cnt_reg <= 4'h1;
  end

  assign recovery_ack_out = (cnt_reg == lat);
  assign retrain_done_out = (cnt_reg == fin);
endmodule : phy_model

// >>> sim/link_control_asserts.sv
// Port checker for the link control register block.
// Assumes it is bound to link_control_reg.
`timescale 1ns/100ps
module link_control_asserts
(
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        downstream_in,
  input wire logic        upstream_ctrl_unlock_in,
  input wire logic        legacy_mode_in,
  input wire logic        eeprom_load_in,
  input wire logic [1:0]  eeprom_aspm_in,
  input wire logic        recovery_ack_in,
  input wire logic [1:0]  aspm_enable_out,
  input wire logic        link_off_out,
  input wire logic        recovery_req_out,
  input wire logic        shared_refclk_flag_out,
  input wire logic        extended_sync_force_out,
  input wire logic        autonomous_width_block_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire logic take = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire logic ctl = take && wb_we_in && wb_sel_in[0]
    && wb_adr_in == link_ctl_pkg::LINK_CONTROL_ADDR;
  wire logic lock = !downstream_in && !upstream_ctrl_unlock_in;

  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  ack_next_a: assert property (take |=> wb_ack_out)
    else $error("request not acknowledged");
  fixed_zero_a: assert property (
    wb_ack_out && !wb_we_in && wb_adr_in == link_ctl_pkg::LINK_CONTROL_ADDR
    |-> (wb_dat_out & 32'hfffff12c) == 32'h0)
    else $error("fixed bits of link control read nonzero");
  field_write_a: assert property (
    ctl && !eeprom_load_in |=> aspm_enable_out == $past(wb_dat_in[1:0])
    && shared_refclk_flag_out == $past(wb_dat_in[6])
    && extended_sync_force_out == $past(wb_dat_in[7]))
    else $error("control fields not updated by write");
  eeprom_load_a: assert property (
    eeprom_load_in |=> aspm_enable_out == $past(eeprom_aspm_in))
    else $error("power field not loaded");
  link_off_a: assert property (
    ctl && downstream_in |=> link_off_out == $past(wb_dat_in[4]))
    else $error("link off output wrong");
  retrain_start_a: assert property (
    ctl && wb_dat_in[5] && !wb_dat_in[4] && !lock |=> recovery_req_out)
    else $error("retrain write did not request recovery");
  retrain_end_a: assert property (
    recovery_req_out && recovery_ack_in && !ctl |=> !recovery_req_out)
    else $error("recovery request stayed after answer");
  up_locked_a: assert property (
    lock && $past(lock) && !recovery_req_out |=> !link_off_out
    && !recovery_req_out)
    else $error("locked upstream port took link control");
  legacy_width_a: assert property (
    legacy_mode_in && $past(legacy_mode_in) |-> !autonomous_width_block_out)
    else $error("width block set in legacy mode");
endmodule : link_control_asserts

bind link_control_reg link_control_asserts chk
(
  .clock_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
  .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .downstream_in,
  .upstream_ctrl_unlock_in, .legacy_mode_in, .eeprom_load_in,
  .eeprom_aspm_in, .recovery_ack_in, .aspm_enable_out, .link_off_out,
  .recovery_req_out, .shared_refclk_flag_out, .extended_sync_force_out,
  .autonomous_width_block_out
);

// >>> sim/pcie_link_control_reg_tb.sv
// Self-checking bench for the link control register block.
// Assumes phy_model as the physical layer and a 25 MHz clock.
`timescale 1ns/100ps
module pcie_link_control_reg_tb;
  logic        clock_in = 1'b0, rst_in = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0]  adr = 8'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        down = 1'b1, unlock = 1'b0, cap = 1'b1, legacy = 1'b0;
  logic        ee_load = 1'b0, slow = 1'b0, os_valid = 1'b0, os_auto = 1'b0;
  logic        dl_down = 1'b0, rel_bw = 1'b0;
  logic [1:0]  ee_aspm = 2'h0, aspm;
  logic        rec_ack, done, loff, rreq, refclk, extended_sync_force, wblk, irq;
  int          mismatches = 0, checked = 0;

  link_control_reg #(.AUTO_TS_RUN(8)) DUT
  (
    .clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .downstream_in(down),
    .upstream_ctrl_unlock_in(unlock), .bw_notify_capable_in(cap),
    .legacy_mode_in(legacy), .eeprom_load_in(ee_load),
    .eeprom_aspm_in(ee_aspm), .recovery_ack_in(rec_ack),
    .retrain_done_in(done), .dl_down_in(dl_down),
    .reliability_bw_change_in(rel_bw), .os_valid_in(os_valid),
    .os_auto_change_in(os_auto), .aspm_enable_out(aspm),
    .link_off_out(loff), .recovery_req_out(rreq),
    .shared_refclk_flag_out(refclk), .extended_sync_force_out(extended_sync_force),
    .autonomous_width_block_out(wblk), .bw_irq_out(irq)
  );
  phy_model phy
  (
    .clock_in(clock_in), .rst_in(rst_in), .recovery_req_in(rreq),
    .slow_in(slow), .recovery_ack_out(rec_ack), .retrain_done_out(done)
  );

  initial
  begin
    forever #20 clock_in = ~clock_in;
  end

  // ==========================================================
  // Shared tasks.
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: %s gave %h, expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Classic single cycle; the request is held until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= d;
    for (n = 0; n < 50 && ack !== 1'b1; n++)
      @(posedge clock_in);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      mismatches++;
      give_verdict;
    end
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp, "read");
  endtask : rd

  task automatic send_os(input int n, input logic a);
    repeat (n)
    begin
      @(posedge clock_in);
      os_valid <= 1'b1;
      os_auto <= a;
    end
    @(posedge clock_in);
    os_valid <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask : send_os

  // ==========================================================
  // Scenarios.
  task automatic sc_basic;
    rd(8'h50, 32'h0);
    bus(1'b1, 8'h40, 32'hffff);
    rd(8'h40, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, 8'h50, 32'hfffff000 | k | (k << 6));
      rd(8'h50, k | (k << 6));
      check(aspm, k, "aspm");
      check({extended_sync_force, refclk}, k, "clock flags");
    end
    bus(1'b1, 8'h50, 32'hffff);
    rd(8'h50, 32'h0ed3);
    check({loff, wblk}, 2'h3, "link off and width block");
    legacy <= 1'b1;
    bus(1'b1, 8'h50, 32'hffff);
    rd(8'h50, 32'h00d3);
    legacy <= 1'b0;
    cap <= 1'b0;
    bus(1'b1, 8'h50, 32'hffff);
    rd(8'h50, 32'h02d3);
    cap <= 1'b1;
    bus(1'b1, 8'h50, 32'h0);
  endtask : sc_basic

  task automatic sc_upstream;
    down <= 1'b0;
    bus(1'b1, 8'h50, 32'h30);
    rd(8'h50, 32'h0);
    check({loff, rreq}, 2'h0, "locked upstream");
    unlock <= 1'b1;
    bus(1'b1, 8'h50, 32'h20);
    check(rreq, 1'b1, "unlocked retrain");
    repeat (12) @(posedge clock_in);
    rd(8'h58, 32'h1);
    bus(1'b1, 8'h58, 32'h1);
    bus(1'b1, 8'h50, 32'h10);
    rd(8'h50, 32'h10);
    check(loff, 1'b1, "unlocked link off");
    bus(1'b1, 8'h50, 32'h0);
    down <= 1'b1;
    unlock <= 1'b0;
  endtask : sc_upstream

  task automatic sc_retrain(input logic s);
    slow <= s;
    bus(1'b1, 8'h50, 32'h462);
    check({rreq, aspm, refclk}, 4'hd, "retrain start");
    rd(8'h50, 32'h442);
    for (int n = 0; n < 30 && q[0] !== 1'b1; n++)
      bus(1'b0, 8'h58, 32'h0);
    check(q[0], 1'b1, "bandwidth flag");
    check(irq, 1'b1, "bandwidth irq");
    bus(1'b1, 8'h58, 32'h1);
    rd(8'h58, 32'h0);
    check(irq, 1'b0, "irq after clear");
  endtask : sc_retrain

  task automatic sc_auto;
    bus(1'b1, 8'h50, 32'h800);
    send_os(7, 1'b1);
    send_os(1, 1'b0);
    rd(8'h58, 32'h0);
    send_os(8, 1'b1);
    rd(8'h58, 32'h2);
    check(irq, 1'b1, "auto irq");
    bus(1'b1, 8'h58, 32'h2);
    @(posedge clock_in);
    ee_aspm <= 2'h3;
    ee_load <= 1'b1;
    @(posedge clock_in);
    ee_load <= 1'b0;
    rd(8'h50, 32'h803);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(8'h50, 32'h0);
    check({aspm, irq}, 3'h0, "outputs after reset");
  endtask : sc_auto

  // A link down during retraining must keep the bandwidth flag clear.
  task automatic sc_link_down;
    bus(1'b1, 8'h50, 32'h20);
    dl_down <= 1'b1;
    @(posedge clock_in);
    dl_down <= 1'b0;
    repeat (20) @(posedge clock_in);
    rd(8'h58, 32'h0);
    rel_bw <= 1'b1;
    @(posedge clock_in);
    rel_bw <= 1'b0;
    rd(8'h58, 32'h1);
    bus(1'b1, 8'h58, 32'h1);
  endtask : sc_link_down

  initial
  begin
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    sc_basic;
    sc_upstream;
    sc_retrain(1'b0);
    sc_retrain(1'b1);
    sc_link_down;
    sc_auto;
    give_verdict;
  end
endmodule : pcie_link_control_reg_tb
